// ### design/umla_defines.svh
`ifndef UMLA_DEFINES_SVH
`define UMLA_DEFINES_SVH

// ****************************************************************
// element and segment geometry
// ****************************************************************
`define UMLA_ESIZE 32
`define UMLA_HSIZE 16
`define UMLA_SEG_BITS 128
`define UMLA_ELTS_PER_SEG 4
`define UMLA_VEC_DIV 8

// ****************************************************************
// operand decode constants
// ****************************************************************
`define UMLA_GPR_PREFIX 3'h2
`define UMLA_VL_DEFAULT 128
`define UMLA_ZREG_COUNT 32

`endif

// ### design/umla_pkg.sv
package umla_pkg;

    // ****************************************************************
    // sequencer states, one-hot
    // ****************************************************************
    typedef enum logic [4:0] {
        UMLA_IDLE = 5'h01,
        UMLA_BASE = 5'h02,
        UMLA_READ = 5'h04,
        UMLA_EXEC = 5'h08,
        UMLA_DONE = 5'h10
    } umla_state_t;

    // ****************************************************************
    // number of accumulator double-vector groups
    // ****************************************************************
    typedef enum logic [1:0] {
        UMLA_G1 = 2'h0,
        UMLA_G2 = 2'h1,
        UMLA_G4 = 2'h2,
        UMLA_GX = 2'h3
    } umla_groups_t;

endpackage

// ### design/umla_acc_if.sv
`timescale 1ns/1ps

// ****************************************************************
// accumulator array port between the engine and its storage
// ****************************************************************
interface umla_acc_if #(
    parameter int W = 128,
    parameter int AW = 4
);
    logic wrEn; // write strobe
    logic [AW-1:0] wrAddr; // vector written
    logic [W-1:0] wrData; // vector contents
    logic rdEn; // read strobe
    logic [AW-1:0] rdAddr; // vector read
    logic [W-1:0] rdData; // registered, one cycle after rdEn

    modport engine (output wrEn, output wrAddr, output wrData,
                    output rdEn, output rdAddr, input rdData);
    modport mem (input wrEn, input wrAddr, input wrData,
                 input rdEn, input rdAddr, output rdData);
endinterface

// ### design/umla_acc_mem.sv
`timescale 1ns/1ps

// ****************************************************************
// accumulator array storage, one vector per word
// ****************************************************************
module umla_acc_mem #(
    parameter int DEPTH = 16
) (
    input wire logic sys_clk, // pipeline clock
    input wire logic reset, // synchronous, active high
    input wire logic ce, // clock enable, freezes all state when low
    umla_acc_if.mem port // engine side
);
    logic [$bits(port.wrData)-1:0] store [DEPTH]; // vector storage, no reset
    logic [$bits(port.wrData)-1:0] rdData_r; // registered read word

    // write port; contents are undefined until software fills them
    always_ff @(posedge sys_clk) begin
        if (ce && port.wrEn) begin
            store[port.wrAddr] <= port.wrData;
        end
    end

    // read port, data stand in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdData_r <= '0;
        end else if (ce && port.rdEn) begin
            rdData_r <= store[port.rdAddr];
        end
    end

    assign port.rdData = rdData_r;
endmodule

// ### design/umla_top.sv
`timescale 1ns/1ps
`include "umla_defines.svh"

module umla_top #(
    parameter int VL = `UMLA_VL_DEFAULT // vector length in bits, multiple of 128
) (
    input wire logic sys_clk, // pipeline clock
    input wire logic reset, // synchronous, active high
    input wire logic ce, // clock enable, freezes all state when low
    input wire logic featureEnabled, // matrix feature version two present
    input wire logic startValid, // issue offers an instruction
    output logic startReady, // engine idle, offer taken
    input wire umla_pkg::umla_groups_t groupSel, // one, two or four groups
    input wire logic [4:0] firstSourceField, // first source register field
    input wire logic [3:0] secondSourceField, // second source register field
    input wire logic [1:0] vectorSelectField, // picks W8..W11
    input wire logic [2:0] offsetThreeBitField, // single group offset
    input wire logic [1:0] offsetTwoBitField, // multi group offset
    input wire logic [1:0] indexHighBits, // element index, upper bits
    input wire logic indexLowBits, // element index, lowest bit
    output logic [4:0] gprAddr, // general register number requested
    input wire logic [63:0] gprData, // register value, same cycle as request
    output logic vregRdEn, // vector register read strobe
    output logic [4:0] vregAAddr, // first source register number
    output logic [4:0] vregBAddr, // second source register number
    input wire logic [VL-1:0] vregAData, // first source, cycle after strobe
    input wire logic [VL-1:0] vregBData, // second source, cycle after strobe
    input wire logic accPeekEn, // inspect accumulator vector while idle
    input wire logic [$clog2(VL/`UMLA_VEC_DIV)-1:0] accPeekAddr, // vector inspected
    output logic [VL-1:0] accPeekData, // inspected vector, cycle after strobe
    output logic busy, // sequence in progress
    output logic done, // one-cycle pulse, last write made
    output logic undefinedInstr // one-cycle pulse, encoding refused
);
    import umla_pkg::*;

    // ****************************************************************
    // geometry
    // ****************************************************************
    localparam int VECTORS = VL / `UMLA_VEC_DIV;
    localparam int AW = $clog2(VECTORS); // accumulator vector address width
    localparam int ELEMS = VL / `UMLA_ESIZE; // accumulator elements per vector
    localparam int STRIDE1 = VECTORS / 1; // whole array per group
    localparam int STRIDE2 = VECTORS / 2; // half array per group
    localparam int STRIDE4 = VECTORS / 4; // quarter array per group

    // ****************************************************************
    // state
    // ****************************************************************
    umla_state_t state_r; // sequencer state
    umla_groups_t groups_r; // captured group count
    logic [4:0] nSeq_r; // first register of the source sequence
    logic [4:0] mReg_r; // second source register
    logic [3:0] offset_r; // immediate vector offset, even
    logic [2:0] index_r; // element index inside each segment
    logic [AW-1:0] vecCur_r; // lowest vector of the current group
    logic [1:0] r_r; // source register step
    logic i_r; // vector within the double-vector group
    logic [4:0] gprAddr_r; // general register request
    logic vregRdEn_r; // vector read strobe
    logic [4:0] vregAAddr_r; // first source request
    logic [4:0] vregBAddr_r; // second source request
    logic done_r; // completion pulse
    logic undef_r; // refusal pulse
    logic [AW-1:0] vecStart; // start vector from base register
    logic [VL-1:0] result; // accumulated vector
    logic lastReg; // current step is last source register
    logic [AW-1:0] strideCur; // stride for captured group count

    umla_acc_if #(.W(VL), .AW(AW)) acc ();

    umla_acc_mem #(.DEPTH(VECTORS)) u_umla_acc_mem (
        .sys_clk(sys_clk),
        .reset(reset),
        .ce(ce),
        .port(acc.mem)
    );

    // ****************************************************************
    // decode helpers
    // ****************************************************************

    // stride per group count; a reserved count falls to the whole-array stride
    function automatic int strideOf(input umla_groups_t g);
        int s;
        s = STRIDE1;
        case (g)
            UMLA_G2: s = STRIDE2;
            UMLA_G4: s = STRIDE4;
            default: s = STRIDE1;
        endcase
        return s;
    endfunction

    // start vector: wide sum so a large base cannot overflow before the wrap
    function automatic logic [AW-1:0] startVec(input logic [31:0] base,
                                               input logic [3:0] off,
                                               input umla_groups_t g);
        logic [32:0] sum;
        logic [32:0] wrapped;
        sum = {1'b0, base} + {29'h0, off};
        wrapped = sum % 33'(strideOf(g));
        wrapped[0] = 1'b0;
        return wrapped[AW-1:0];
    endfunction

    assign strideCur = AW'(strideOf(groups_r));
    assign vecStart = startVec(gprData[31:0], offset_r, groups_r);
    assign lastReg = (groups_r == UMLA_G1) ? 1'b1 :
                     (groups_r == UMLA_G2) ? (r_r == 2'h1) : (r_r == 2'h3);

    // ****************************************************************
    // element datapath
    // ****************************************************************

    // one lane per 32-bit accumulator element; unsigned, unpredicated
    for (genvar e = 0; e < ELEMS; e++) begin : g_elem
        localparam int SEGBASE = e - (e % `UMLA_ELTS_PER_SEG);
        logic [`UMLA_HSIZE-1:0] opA; // first source halfword
        logic [`UMLA_HSIZE-1:0] opB; // indexed multiplier halfword
        logic [`UMLA_ESIZE-1:0] prod; // widened product
        assign opA = vregAData[(2*e + int'(i_r))*`UMLA_HSIZE +: `UMLA_HSIZE];
        assign opB = vregBData[(2*SEGBASE + int'(index_r))*`UMLA_HSIZE +:
                               `UMLA_HSIZE];
        // 16x16 fills exactly 32 bits, so truncation is a no-op here
        assign prod = {16'h0, opA} * {16'h0, opB};
        // plain modular add: no saturation and no carry out kept
        assign result[e*`UMLA_ESIZE +: `UMLA_ESIZE] =
            acc.rdData[e*`UMLA_ESIZE +: `UMLA_ESIZE] + prod;
    end

    // ****************************************************************
    // accumulator port
    // ****************************************************************

    // engine reads in READ; host peeks only while idle so no conflict
    always_comb begin
        acc.rdEn = 1'b0;
        acc.rdAddr = accPeekAddr;
        if (state_r == UMLA_READ) begin
            acc.rdEn = 1'b1;
            acc.rdAddr = vecCur_r + AW'(i_r);
        end else if (state_r == UMLA_IDLE) begin
            acc.rdEn = accPeekEn;
        end
    end

    // write back into the very vector that was read
    always_comb begin
        acc.wrEn = (state_r == UMLA_EXEC);
        acc.wrAddr = vecCur_r + AW'(i_r);
        acc.wrData = result;
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************

    // state progression; reserved group count is refused like a missing feature
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_r <= UMLA_IDLE;
        end else if (ce) begin
            case (state_r)
                UMLA_IDLE: begin
                    if (startValid && featureEnabled && groupSel != UMLA_GX) begin
                        state_r <= UMLA_BASE;
                    end
                end
                UMLA_BASE: begin
                    state_r <= UMLA_READ;
                end
                UMLA_READ: begin
                    state_r <= UMLA_EXEC;
                end
                UMLA_EXEC: begin
                    state_r <= (i_r && lastReg) ? UMLA_DONE : UMLA_READ;
                end
                UMLA_DONE: begin
                    state_r <= UMLA_IDLE;
                end
                default: begin
                    state_r <= UMLA_IDLE;
                end
            endcase
        end
    end

    // operand capture at acceptance
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            groups_r <= UMLA_G1;
            nSeq_r <= 5'h00;
            mReg_r <= 5'h00;
            offset_r <= 4'h0;
            index_r <= 3'h0;
        end else if (ce && state_r == UMLA_IDLE && startValid) begin
            groups_r <= groupSel;
            mReg_r <= {1'b0, secondSourceField};
            index_r <= {indexHighBits, indexLowBits};
            case (groupSel)
                UMLA_G2: begin
                    nSeq_r <= {firstSourceField[3:0], 1'b0};
                    offset_r <= {1'b0, offsetTwoBitField, 1'b0};
                end
                UMLA_G4: begin
                    nSeq_r <= {firstSourceField[2:0], 2'h0};
                    offset_r <= {1'b0, offsetTwoBitField, 1'b0};
                end
                default: begin
                    nSeq_r <= firstSourceField;
                    offset_r <= {offsetThreeBitField, 1'b0};
                end
            endcase
        end
    end

    // general register request for W8..W11
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            gprAddr_r <= 5'h00;
        end else if (ce && state_r == UMLA_IDLE && startValid) begin
            gprAddr_r <= {`UMLA_GPR_PREFIX, vectorSelectField};
        end
    end

    // step counters and current group vector
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            vecCur_r <= '0;
            r_r <= 2'h0;
            i_r <= 1'b0;
        end else if (ce) begin
            if (state_r == UMLA_BASE) begin
                vecCur_r <= vecStart;
                r_r <= 2'h0;
                i_r <= 1'b0;
            end else if (state_r == UMLA_EXEC) begin
                i_r <= ~i_r;
                if (i_r) begin
                    r_r <= r_r + 2'h1;
                    vecCur_r <= vecCur_r + strideCur;
                end
            end
        end
    end

    // vector register requests, presented throughout READ
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            vregRdEn_r <= 1'b0;
            vregAAddr_r <= 5'h00;
            vregBAddr_r <= 5'h00;
        end else if (ce) begin
            vregRdEn_r <= 1'b0;
            if (state_r == UMLA_BASE) begin
                vregRdEn_r <= 1'b1;
                vregAAddr_r <= nSeq_r;
                vregBAddr_r <= mReg_r;
            end else if (state_r == UMLA_EXEC && !(i_r && lastReg)) begin
                vregRdEn_r <= 1'b1;
                // the source step moves after the second vector of a group
                vregAAddr_r <= nSeq_r + {3'h0, r_r} + {4'h0, i_r};
                vregBAddr_r <= mReg_r;
            end
        end
    end

    // completion and refusal pulses
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            done_r <= 1'b0;
            undef_r <= 1'b0;
        end else if (ce) begin
            done_r <= (state_r == UMLA_EXEC) && i_r && lastReg;
            undef_r <= (state_r == UMLA_IDLE) && startValid &&
                       (!featureEnabled || groupSel == UMLA_GX);
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign startReady = (state_r == UMLA_IDLE);
    assign busy = (state_r != UMLA_IDLE);
    assign done = done_r;
    assign undefinedInstr = undef_r;
    assign gprAddr = gprAddr_r;
    assign vregRdEn = vregRdEn_r;
    assign vregAAddr = vregAAddr_r;
    assign vregBAddr = vregBAddr_r;
    assign accPeekData = acc.rdData;
endmodule

// ### tb/umla_partner.sv
`timescale 1ns/1ps

// ****************
// register files on the issue side of the engine
// ****************
module umla_partner #(
    parameter int VL = 128 // vector length in bits
) (
    input wire logic sys_clk, // pipeline clock
    input wire logic [4:0] gprAddr, // general register asked for
    output logic [63:0] gprData, // its value
    input wire logic vregRdEn, // vector read strobe
    input wire logic [4:0] vregAAddr, // first source number
    input wire logic [4:0] vregBAddr, // second source number
    output logic [VL-1:0] vregAData, // cycle after strobe
    output logic [VL-1:0] vregBData // cycle after strobe
);
    logic [63:0] gpr [32]; // general registers
    logic [VL-1:0] vreg [32]; // vector registers
    // comb lookup, address held by the engine
    assign gprData = gpr[gprAddr];
    // one cycle of data, then flipped: late samples fail
    always_ff @(posedge sys_clk) begin
        if (vregRdEn) begin
            vregAData <= vreg[vregAAddr];
            vregBData <= vreg[vregBAddr];
        end else begin
            vregAData <= ~vregAData;
            vregBData <= ~vregBData;
        end
    end
endmodule

// ### tb/umla_top_monitor.sv
`timescale 1ns/1ps

// ****************
// port checker for the multiply-add engine
// ****************
module umla_top_monitor
    import umla_pkg::*;
#(
    parameter int VL = 128 // vector length in bits
) (
    input wire logic sys_clk, // pipeline clock
    input wire logic reset, // synchronous, active high
    input wire logic ce, // clock enable
    input wire logic featureEnabled, // feature present
    input wire logic startValid, // issue offer
    input wire logic startReady, // engine idle
    input wire umla_pkg::umla_groups_t groupSel, // variant
    input wire logic [4:0] firstSourceField, // first source field
    input wire logic [3:0] secondSourceField, // second source field
    input wire logic [1:0] vectorSelectField, // select register field
    input wire logic [4:0] gprAddr, // general register asked
    input wire logic vregRdEn, // vector read strobe
    input wire logic [4:0] vregAAddr, // first source number
    input wire logic [4:0] vregBAddr, // second source number
    input wire logic busy, // sequence running
    input wire logic done, // end pulse
    input wire logic undefinedInstr // refusal pulse
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    logic take; // offer taken this cycle
    logic ok; // taken and decodable
    logic [4:0] busyCnt_r; // busy cycles so far
    logic [2:0] nreg_r; // groups of the running sequence
    logic [3:0] rdCnt_r; // vector reads so far
    assign take = startValid && startReady && ce;
    assign ok = take && featureEnabled && groupSel != UMLA_GX;
    // frozen with ce, so a stalled sequence keeps its count
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            busyCnt_r <= 5'h0;
        end else if (ce) begin
            busyCnt_r <= busy ? busyCnt_r + 5'h1 : 5'h0;
        end
    end
    // tallies restart at each accepted start
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            nreg_r <= 3'h0;
            rdCnt_r <= 4'h0;
        end else if (ok) begin
            nreg_r <= groupSel == UMLA_G1 ? 3'h1 : groupSel == UMLA_G2 ? 3'h2 : 3'h4;
            rdCnt_r <= 4'h0;
        end else if (ce && vregRdEn) begin
            rdCnt_r <= rdCnt_r + 4'h1;
        end
    end
    AST_UNDEF_OFF: assert property (take && !featureEnabled |=> undefinedInstr && !busy)
        else $error("start without feature not refused");
    AST_UNDEF_RSVD: assert property (take && groupSel == UMLA_GX |=> undefinedInstr)
        else $error("reserved group count not refused");
    AST_BASE_REG: assert property (ok |=> gprAddr == {3'h2, $past(vectorSelectField)})
        else $error("wrong select register");
    AST_SRC_ONE: assert property (ok && groupSel == UMLA_G1 ##1 ce ##1 ce |->
        vregRdEn && vregAAddr == $past(firstSourceField, 2))
        else $error("single group source wrong");
    AST_SRC_TWO: assert property (ok && groupSel == UMLA_G2 ##1 ce ##1 ce |->
        vregRdEn && vregAAddr == {$past(firstSourceField[3:0], 2), 1'b0})
        else $error("two group source wrong");
    AST_SRC_FOUR: assert property (ok && groupSel == UMLA_G4 ##1 ce ##1 ce |->
        vregRdEn && vregAAddr == {$past(firstSourceField[2:0], 2), 2'h0})
        else $error("four group source wrong");
    AST_SRC_B: assert property (ok ##1 ce ##1 ce |->
        vregBAddr == {1'b0, $past(secondSourceField, 2)})
        else $error("second source wrong");
    AST_DONE_LEN: assert property (done |-> busyCnt_r == {nreg_r, 2'h0} + 5'h1)
        else $error("sequence length wrong");
    AST_DONE_READS: assert property (done |-> rdCnt_r == {nreg_r, 1'b0})
        else $error("read count wrong");
    cover property (ok && groupSel == UMLA_G1);
    cover property (ok && groupSel == UMLA_G2);
    cover property (ok && groupSel == UMLA_G4);
    cover property (undefinedInstr);
endmodule

bind umla_top umla_top_monitor #(.VL(VL)) u_umla_top_monitor (.sys_clk(sys_clk),
    .reset(reset), .ce(ce), .featureEnabled(featureEnabled), .startValid(startValid),
    .startReady(startReady), .groupSel(groupSel), .firstSourceField(firstSourceField),
    .secondSourceField(secondSourceField), .vectorSelectField(vectorSelectField),
    .gprAddr(gprAddr), .vregRdEn(vregRdEn), .vregAAddr(vregAAddr), .vregBAddr(vregBAddr),
    .busy(busy), .done(done), .undefinedInstr(undefinedInstr));

// ### tb/test_umla_top.sv
`timescale 1ns/1ps

// ****************
// bench for the multiply-add engine
// ****************
module test_umla_top;
    import umla_pkg::*;
    localparam int VL = 256; // two segments per vector
    localparam int NV = VL / 8; // accumulator vectors
    logic sys_clk, reset, ce, featureEnabled, startValid, indexLowBits; // control
    umla_groups_t groupSel; // variant
    logic [4:0] firstSourceField, gprAddr, vregAAddr, vregBAddr; // register numbers
    logic [3:0] secondSourceField; // second source field
    logic [1:0] vectorSelectField, offsetTwoBitField, indexHighBits; // small fields
    logic [2:0] offsetThreeBitField; // single group offset
    logic startReady, vregRdEn, busy, done, undefinedInstr, accPeekEn; // handshakes
    logic [63:0] gprData; // base register value
    logic [VL-1:0] vregAData, vregBData, accPeekData; // vectors
    logic [$clog2(NV)-1:0] accPeekAddr; // vector inspected
    logic [VL-1:0] accM [NV]; // expected accumulator
    int miscompares = 0, checked = 0; // tallies
    umla_top #(.VL(VL)) u_umla_top (.sys_clk(sys_clk), .reset(reset), .ce(ce),
        .featureEnabled(featureEnabled), .startValid(startValid), .startReady(startReady),
        .groupSel(groupSel), .firstSourceField(firstSourceField),
        .secondSourceField(secondSourceField), .vectorSelectField(vectorSelectField),
        .offsetThreeBitField(offsetThreeBitField), .offsetTwoBitField(offsetTwoBitField),
        .indexHighBits(indexHighBits), .indexLowBits(indexLowBits), .gprAddr(gprAddr),
        .gprData(gprData), .vregRdEn(vregRdEn), .vregAAddr(vregAAddr), .vregBAddr(vregBAddr),
        .vregAData(vregAData), .vregBData(vregBData), .accPeekEn(accPeekEn),
        .accPeekAddr(accPeekAddr), .accPeekData(accPeekData), .busy(busy), .done(done),
        .undefinedInstr(undefinedInstr));
    umla_partner #(.VL(VL)) u_umla_partner (.sys_clk(sys_clk), .gprAddr(gprAddr),
        .gprData(gprData), .vregRdEn(vregRdEn), .vregAAddr(vregAAddr),
        .vregBAddr(vregBAddr), .vregAData(vregAData), .vregBData(vregBData));
    always #10 sys_clk = ~sys_clk;
    task automatic stop_test;
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check_val(input logic [VL-1:0] got, input logic [VL-1:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // answers only while idle, a cycle after the strobe
    task automatic peek(input int a, output logic [VL-1:0] d);
        @(posedge sys_clk);
        accPeekEn <= 1'b1;
        accPeekAddr <= a[$clog2(NV)-1:0];
        @(posedge sys_clk);
        accPeekEn <= 1'b0;
        #1;
        d = accPeekData;
    endtask
    task automatic check_acc;
        logic [VL-1:0] d;
        for (int k = 0; k < NV; k++) begin
            peek(k, d);
            check_val(d, accM[k]);
        end
    endtask
    // one start with its reads checked, then the expected sums
    task automatic run_op(input umla_groups_t g, input logic [4:0] fs, input logic [3:0] ss,
        input logic [1:0] vs, input logic [2:0] o3, input logic [1:0] o2,
        input logic [2:0] ix, input logic [63:0] base);
        int nreg, n, stride, vec, cyc, rd, s;
        longint unsigned sum;
        logic [VL-1:0] a, b;
        logic [31:0] p;
        nreg = (g == UMLA_G1) ? 1 : (g == UMLA_G2) ? 2 : 4;
        n = (g == UMLA_G1) ? fs : (g == UMLA_G2) ? {fs[3:0], 1'b0} : {fs[2:0], 2'b00};
        stride = NV / nreg;
        sum = base[31:0];
        sum = sum + ((g == UMLA_G1) ? 2 * o3 : 2 * o2);
        vec = int'(sum % longint'(stride));
        vec = vec - vec % 2;
        u_umla_partner.gpr[8 + vs] = base;
        @(posedge sys_clk);
        startValid <= 1'b1;
        groupSel <= g;
        firstSourceField <= fs;
        secondSourceField <= ss;
        vectorSelectField <= vs;
        offsetThreeBitField <= o3;
        offsetTwoBitField <= o2;
        indexHighBits <= ix[2:1];
        indexLowBits <= ix[0];
        @(posedge sys_clk);
        startValid <= 1'b0;
        cyc = 1;
        rd = 0;
        #1;
        check_val(VL'(gprAddr), VL'({3'h2, vs}));
        while (done !== 1'b1 && cyc < 40) begin
            if (vregRdEn === 1'b1) begin
                check_val(VL'(vregAAddr), VL'((n + rd / 2) % 32));
                check_val(VL'(vregBAddr), VL'({1'b0, ss}));
                rd++;
            end
            @(posedge sys_clk);
            #1;
            cyc++;
        end
        check_val(VL'(cyc), VL'(2 + 4 * nreg));
        check_val(VL'(rd), VL'(2 * nreg));
        for (int r = 0; r < nreg; r++) begin
            a = u_umla_partner.vreg[(n + r) % 32];
            b = u_umla_partner.vreg[ss];
            for (int i = 0; i < 2; i++) begin
                for (int e = 0; e < VL / 32; e++) begin
                    s = 2 * (e - e % 4) + ix;
                    p = a[16 * (2 * e + i) +: 16] * b[16 * s +: 16];
                    accM[vec + i][32 * e +: 32] += p;
                end
            end
            vec += stride;
        end
    endtask
    task automatic refuse(input logic feat, input umla_groups_t g);
        @(posedge sys_clk);
        featureEnabled <= feat;
        groupSel <= g;
        startValid <= 1'b1;
        @(posedge sys_clk);
        startValid <= 1'b0;
        #1;
        check_val(VL'(undefinedInstr), VL'(1));
        check_val(VL'(busy), VL'(0));
        @(posedge sys_clk);
        featureEnabled <= 1'b1;
        #1;
        check_val(VL'(undefinedInstr), VL'(0));
    endtask
    task automatic test_refusals;
        refuse(1'b0, UMLA_G1);
        refuse(1'b0, UMLA_G4);
        refuse(1'b1, UMLA_GX);
        check_acc();
    endtask
    task automatic test_single;
        run_op(UMLA_G1, 5'h1f, 4'hf, 2'h3, 3'h7, 2'h0, 3'h7, 64'h1234_5678_0000_0003);
        check_acc();
    endtask
    task automatic test_double;
        run_op(UMLA_G2, 5'h1f, 4'h0, 2'h0, 3'h7, 2'h3, 3'h0, 64'hffff_ffff_ffff_ffff);
        check_acc();
    endtask
    task automatic test_quad;
        run_op(UMLA_G4, 5'h1d, 4'h9, 2'h1, 3'h0, 2'h1, 3'h4, 64'h5);
        check_acc();
    endtask
    // back-to-back starts over every index
    task automatic test_index_sweep;
        for (int x = 0; x < 8; x++) begin
            run_op(UMLA_G1, 5'(x * 3), 4'(x), 2'(x), 3'(x), 2'h0, 3'(x), 64'(x * 5));
        end
        run_op(UMLA_G4, 5'h1f, 4'h3, 2'h2, 3'h0, 2'h3, 3'h6, 64'h8);
        check_acc();
    endtask
    initial begin
        repeat (5000) @(posedge sys_clk);
        miscompares++;
        stop_test();
    end
    initial begin
        sys_clk = 1'b0;
        reset = 1'b1;
        ce = 1'b1;
        featureEnabled = 1'b1;
        startValid = 1'b0;
        groupSel = UMLA_G1;
        firstSourceField = 5'h0;
        secondSourceField = 4'h0;
        vectorSelectField = 2'h0;
        offsetThreeBitField = 3'h0;
        offsetTwoBitField = 2'h0;
        indexHighBits = 2'h0;
        indexLowBits = 1'b0;
        accPeekEn = 1'b0;
        accPeekAddr = '0;
        for (int k = 0; k < 32; k++) begin
            u_umla_partner.gpr[k] = 64'h0;
            for (int h = 0; h < VL / 16; h++) begin
                u_umla_partner.vreg[k][16 * h +: 16] = 16'hffff ^ 16'(k * 37 + h * 11);
            end
            accM[k] = {VL / 32{32'hffff_0000 | 32'(k)}}; // near the top, so sums wrap
            u_umla_top.u_umla_acc_mem.store[k] = accM[k];
        end
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        test_refusals();
        test_single();
        test_double();
        test_quad();
        test_index_sweep();
        stop_test();
    end
endmodule
